// ===== epi_defines.svh
// Purpose: Constants for the external pin interrupt controller.
// Assumes: Word addresses are 5 bits wide.
// Notes: Included by the package, the controller module and the testbench.
`ifndef EPI_DEFINES_SVH
`define EPI_DEFINES_SVH
`define EPI_VEC_RESET 5'h00
`define EPI_VEC_EXT 5'h01
`define EPI_VEC_GRP0 5'h02
`define EPI_VEC_OTHER_FIRST 5'h05
`define EPI_VEC_OTHER_LAST 5'h11
`define EPI_OTHER_COUNT 13
`define EPI_GRP0_LO 0
`define EPI_GRP0_HI 7
`define EPI_GRP1_LO 8
`define EPI_GRP1_HI 11
`define EPI_GRP2_LO 12
`define EPI_GRP2_HI 17
`define EPI_SENSE_LOW 2'h0
`define EPI_SENSE_ANY 2'h1
`define EPI_SENSE_FALL 2'h2
`define EPI_SENSE_RISE 2'h3
`define EPI_SENSE_RESET 2'h0
`endif

// ===== epi_pkg.sv
// Purpose: Types shared by the interrupt controller modules.
// Assumes: Nothing beyond the defines header.
// Notes: Holds types only.
`include "epi_defines.svh"
package epi_pkg;
    typedef enum logic [1:0] {
        EPI_ST_RUN = 2'b00,
        EPI_ST_ACK = 2'b01
    } epi_state_t;
    typedef struct packed {
        logic [7:0] mask0;
        logic [3:0] mask1;
        logic [5:0] mask2;
    } epi_masks_t;
    typedef struct packed {
        logic valid;
        logic [4:0] addr;
    } epi_vec_t;
endpackage : epi_pkg

// ===== epi_sync.sv
// Purpose: Two flip-flop synchroniser for a bus of pin levels.
// Assumes: Inputs are asynchronous to clk_i.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/100ps
module epi_sync #(
    parameter int WIDTH = 19
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] q_reg;
    initial begin
        if (WIDTH < 1) begin
            $error("epi_sync: WIDTH must be positive.");
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_reg <= '1;
            q_reg <= '1;
        end else begin
            s1_reg <= d_i;
            q_reg <= s1_reg;
        end
    end
    assign q_o = q_reg;
endmodule : epi_sync

// ===== epi_ctrl.sv
// Purpose: External pin and pin-change interrupt detection with vector dispatch.
// Assumes: One clock; io_clk_run_i marks when the I/O clock would run.
// Notes: Pins idle high; asynchronous wake is a combinational level output.
// Behaviour
// - After any reset the vector address output is word 0x0000.
// - External pin goes to 0x0001, pin-change groups to 0x0002..0x0004.
// - Other sources take words 0x0005 to 0x0011 in table order.
// - Detection ignores pin direction; pin levels are observed as they are.
// - Group 0 requests on any enabled toggle among inputs 7:0.
// - Group 1 requests on any enabled toggle among inputs 11:8.
// - Group 2 requests on any enabled toggle among inputs 17:12.
// - Only inputs whose mask bit is set contribute to their group.
// - Pin-change wake is raised without the I/O clock running.
// - External pin senses any change, falling edge, rising edge or low level.
// - Level mode requests continuously while the pin stays low.
// - Edge detection happens only while the I/O clock runs.
// - Low level wakes without the I/O clock.
// - Wake-up low level must last through start-up or no request follows.
// - Level gone before wake completes means no handler entry.
// - Sense codes: 0 low, 1 any change, 2 falling, 3 rising.
// - Pulses longer than one clock period are detected while the I/O clock runs.
// - Group flags set on trigger, clear on service or software write one.
// - External flag reads cleared while level mode is selected.
`timescale 1ns/100ps
`include "epi_defines.svh"
module epi_ctrl
    import epi_pkg::*;
#(
    parameter int OTHER_COUNT = `EPI_OTHER_COUNT
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ext_irq_pin_i,
    input wire logic [17:0] pin_change_inputs_i,
    input wire logic [1:0] sense_select_i,
    input wire logic ext_irq_en_i,
    input wire logic [2:0] pin_group_en_i,
    input wire epi_masks_t masks_i,
    input wire logic io_clk_run_i,
    input wire logic started_i,
    input wire logic [3:0] flag_clear_i,
    input wire logic [OTHER_COUNT-1:0] other_req_i,
    input wire logic global_en_i,
    input wire logic ack_i,
    output logic [3:0] flags_o,
    output logic [2:0] group_req_o,
    output epi_vec_t vec_o,
    output logic wake_o
);
    logic [18:0] pins_s;
    logic [18:0] prev_reg, prev_next;
    logic [3:0] flag_reg, flag_next;
    logic [2:0] greq_reg, greq_next;
    epi_vec_t vec_reg, vec_next;
    epi_state_t st_reg, st_next;
    logic [17:0] mask_all;
    logic [17:0] changed;
    logic [2:0] grp_hit;
    logic ext_sync, ext_prev, ext_edge, level_mode, level_req;
    logic [OTHER_COUNT+3:0] pend;
    initial begin
        if (OTHER_COUNT != `EPI_OTHER_COUNT) begin
            $error("epi_ctrl: OTHER_COUNT must match the vector table.");
        end
    end
    // pins are sampled as levels regardless of who drives them.
    epi_sync #(.WIDTH(19)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({ext_irq_pin_i, pin_change_inputs_i}),
        .q_o(pins_s)
    );
    function automatic logic [4:0] pick_vec(input logic [OTHER_COUNT+3:0] p);
        logic [4:0] v;
        v = `EPI_VEC_RESET;
        for (int i = OTHER_COUNT + 3; i >= 0; i--) begin
            if (p[i]) begin
                v = 5'(i + 1);
            end
        end
        return v;
    endfunction : pick_vec
    assign ext_sync = pins_s[18];
    assign ext_prev = prev_reg[18];
    assign mask_all = {masks_i.mask2, masks_i.mask1, masks_i.mask0};
    assign changed = (pins_s[17:0] ^ prev_reg[17:0]) & mask_all;
    assign grp_hit[0] = |changed[`EPI_GRP0_HI:`EPI_GRP0_LO];
    assign grp_hit[1] = |changed[`EPI_GRP1_HI:`EPI_GRP1_LO];
    assign grp_hit[2] = |changed[`EPI_GRP2_HI:`EPI_GRP2_LO];
    assign level_mode = (sense_select_i == `EPI_SENSE_LOW);
    // synchronised edge compare catches any pulse over one period while io_clk_run_i is high.
    always_comb begin
        ext_edge = 1'b0;
        if (io_clk_run_i) begin
            case (sense_select_i)
                `EPI_SENSE_ANY: ext_edge = ext_sync ^ ext_prev;
                `EPI_SENSE_FALL: ext_edge = ext_prev & ~ext_sync;
                `EPI_SENSE_RISE: ext_edge = ~ext_prev & ext_sync;
                default: ext_edge = 1'b0;
            endcase
        end
    end
    // Level request only after start-up, so a level that vanished early is dropped.
    assign level_req = level_mode & ext_irq_en_i & ~ext_sync & started_i;
    always_comb begin
        prev_next = pins_s;
        flag_next = flag_reg;
        // Set wins over clear in the same cycle.
        if (flag_clear_i[0]) flag_next[0] = 1'b0;
        if (ext_edge) flag_next[0] = 1'b1;
        if (level_mode) flag_next[0] = 1'b0;
        for (int g = 0; g < 3; g++) begin
            if (flag_clear_i[g+1]) flag_next[g+1] = 1'b0;
            if (grp_hit[g]) flag_next[g+1] = 1'b1;
        end
        greq_next = grp_hit;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_reg <= '1;
            flag_reg <= 4'h0;
            greq_reg <= 3'h0;
        end else begin
            prev_reg <= prev_next;
            flag_reg <= flag_next;
            greq_reg <= greq_next;
        end
    end
    // mismatch of raw pins against last sampled level is clock-free.
    logic [17:0] raw_change;
    assign raw_change = (pin_change_inputs_i ^ prev_reg[17:0]) & mask_all;
    always_comb begin
        // Wake stays combinational because a halted clock must not be able to block it.
        wake_o = (|raw_change)
            | (level_mode & ext_irq_en_i & ~ext_irq_pin_i);
    end
    always_comb begin
        pend = {other_req_i,
                flag_reg[3] & pin_group_en_i[2],
                flag_reg[2] & pin_group_en_i[1],
                flag_reg[1] & pin_group_en_i[0],
                (flag_reg[0] & ext_irq_en_i) | level_req};
        vec_next = vec_reg;
        st_next = st_reg;
        case (st_reg)
            EPI_ST_RUN: begin
                vec_next.valid = global_en_i & (|pend);
                vec_next.addr = pick_vec(pend);
                if (ack_i & vec_reg.valid) begin
                    st_next = EPI_ST_ACK;
                    vec_next.valid = 1'b0;
                end
            end
            EPI_ST_ACK: begin
                vec_next.valid = 1'b0;
                st_next = EPI_ST_RUN;
            end
            default: st_next = EPI_ST_RUN;
        endcase
    end
    // Service clears arrive from the core on flag_clear_i; there is no internal auto-clear.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vec_reg <= '{valid: 1'b0, addr: `EPI_VEC_RESET};
            st_reg <= EPI_ST_RUN;
        end else begin
            vec_reg <= vec_next;
            st_reg <= st_next;
        end
    end
    assign flags_o = flag_reg;
    assign group_req_o = greq_reg;
    assign vec_o = vec_reg;
    property p_level_clears_flag;
        @(posedge clk_i) disable iff (rst_i)
        level_mode |=> !flag_reg[0];
    endproperty
    a_level_clears_flag: assert property (p_level_clears_flag)
        else $error("External flag set in level mode.");
    // Checked through reset itself, so no disable clause here.
    property p_reset_vec;
        @(posedge clk_i)
        rst_i |=> vec_reg.addr == `EPI_VEC_RESET && !vec_reg.valid && flag_reg == 4'h0;
    endproperty
    a_reset_vec: assert property (p_reset_vec)
        else $error("Reset state not applied.");
    property p_group_set0;
        @(posedge clk_i) disable iff (rst_i)
        grp_hit[0] |=> flag_reg[1];
    endproperty
    a_group_set0: assert property (p_group_set0)
        else $error("Group 0 flag not set.");
    property p_group_set1;
        @(posedge clk_i) disable iff (rst_i)
        grp_hit[1] |=> flag_reg[2];
    endproperty
    a_group_set1: assert property (p_group_set1)
        else $error("Group 1 flag not set.");
    property p_group_set2;
        @(posedge clk_i) disable iff (rst_i)
        grp_hit[2] |=> flag_reg[3];
    endproperty
    a_group_set2: assert property (p_group_set2)
        else $error("Group 2 flag not set.");
    property p_group_clear;
        @(posedge clk_i) disable iff (rst_i)
        flag_clear_i[1] && !grp_hit[0] |=> !flag_reg[1];
    endproperty
    a_group_clear: assert property (p_group_clear)
        else $error("Group 0 flag not cleared by write one.");
    property p_no_edge_halted;
        @(posedge clk_i) disable iff (rst_i)
        !io_clk_run_i && !level_mode && !flag_reg[0] && !flag_clear_i[0] |=> !flag_reg[0];
    endproperty
    a_no_edge_halted: assert property (p_no_edge_halted)
        else $error("Edge seen with halted clock.");
    property p_fall;
        @(posedge clk_i) disable iff (rst_i)
        io_clk_run_i && sense_select_i == `EPI_SENSE_FALL && $fell(ext_sync) |=> flag_reg[0];
    endproperty
    a_fall: assert property (p_fall)
        else $error("Falling edge missed.");
    property p_prio;
        @(posedge clk_i) disable iff (rst_i)
        st_reg == EPI_ST_RUN && global_en_i && pend[0] && !(ack_i && vec_reg.valid)
        |=> vec_reg.addr == `EPI_VEC_EXT;
    endproperty
    a_prio: assert property (p_prio)
        else $error("Priority wrong.");
    property p_level;
        @(posedge clk_i) disable iff (rst_i)
        level_req && global_en_i && st_reg == EPI_ST_RUN && !(ack_i && vec_reg.valid)
        |=> vec_reg.valid;
    endproperty
    a_level: assert property (p_level)
        else $error("Level request not held.");
endmodule : epi_ctrl

// ===== epi_core_model.sv
// Purpose: Core-side model that takes vectored requests and services them.
// Assumes: Flags are cleared by a one-cycle pulse when a handler is entered.
// Notes: slow_i stretches the answer; at least two idle cycles follow an ack.
`timescale 1ns/100ps
module epi_core_model
    import epi_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire epi_vec_t vec_i,
    input wire logic en_i,
    input wire logic slow_i,
    output logic ack_o,
    output logic [3:0] clr_o
);
    logic [2:0] dly_reg;
    // The idle count lets the cleared flag reach vec_i before a second ack.
    always_ff @(posedge clk_i) begin
        ack_o <= 1'b0;
        clr_o <= 4'h0;
        if (rst_i || !en_i || !vec_i.valid || ack_o) begin
            dly_reg <= 3'h0;
        end else if (dly_reg == (slow_i ? 3'h5 : 3'h2)) begin
            ack_o <= 1'b1;
            dly_reg <= 3'h0;
            if (vec_i.addr >= 5'h01 && vec_i.addr <= 5'h04) begin
                clr_o <= 4'h1 << (vec_i.addr - 5'h01);
            end
        end else begin
            dly_reg <= dly_reg + 3'h1;
        end
    end
endmodule : epi_core_model

// ===== epi_ctrl_test.sv
// Purpose: Self-checking bench for the pin interrupt controller.
// Assumes: Inputs change at the falling edge; flags settle within six cycles.
// Notes: Pins start high; the core model acks only where a scenario enables it.
`timescale 1ns/100ps
`include "epi_defines.svh"
module epi_ctrl_test;
    import epi_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, pin = 1'b1, io_run = 1'b1, started = 1'b1;
    logic ext_en = 1'b1, gen = 1'b1, m_en = 1'b0, m_slow = 1'b0, ack;
    // Pins idle high, matching the level the synchroniser takes in reset.
    logic [17:0] pc = 18'h3FFFF;
    logic seen_clr = 1'b1;
    logic [1:0] sense = `EPI_SENSE_FALL;
    logic [2:0] grp_en = 3'h7, greq, seen;
    logic [3:0] tb_clr = 4'h0, m_clr, flags;
    logic [12:0] other = 13'h0;
    logic wake;
    epi_masks_t masks = '{mask0: 8'h80, mask1: 4'h1, mask2: 6'h20};
    epi_vec_t vec;
    logic [4:0] q[$];
    int err_count = 0, checked = 0;
    always #2.5 clk_i = ~clk_i;
    epi_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .ext_irq_pin_i(pin),
        .pin_change_inputs_i(pc), .sense_select_i(sense), .ext_irq_en_i(ext_en),
        .pin_group_en_i(grp_en), .masks_i(masks), .io_clk_run_i(io_run),
        .started_i(started), .flag_clear_i(tb_clr | m_clr), .other_req_i(other),
        .global_en_i(gen), .ack_i(ack), .flags_o(flags), .group_req_o(greq),
        .vec_o(vec), .wake_o(wake));
    epi_core_model core (.clk_i(clk_i), .rst_i(rst_i), .vec_i(vec), .en_i(m_en),
        .slow_i(m_slow), .ack_o(ack), .clr_o(m_clr));
    always @(posedge clk_i) begin
        seen <= seen_clr ? 3'h0 : (seen | greq);
        if (ack) q.push_back(vec.addr);
    end
    task automatic chk(input string nm, input logic [5:0] exp, input logic [5:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask : cyc
    task automatic wclr(input int b);
        tb_clr = 4'h1 << b;
        cyc(1);
        tb_clr = 4'h0;
        cyc(2);
    endtask : wclr
    task automatic t_groups;
        int mi[3] = '{7, 8, 17};
        int ui[3] = '{0, 9, 12};
        for (int g = 0; g < 3; g++) begin
            seen_clr = 1'b1;
            pc[ui[g]] = ~pc[ui[g]];
            #1;
            chk("unmasked wake", 6'h00, {5'h0, wake});
            cyc(6);
            chk("unmasked", 6'h00, {2'h0, flags});
            seen_clr = 1'b0;
            pc[mi[g]] = ~pc[mi[g]];
            #1;
            chk("pin wake", 6'h01, {5'h0, wake});
            cyc(6);
            chk("group flag", 6'h1 << (g + 1), {2'h0, flags});
            chk("group pulse", 6'h1 << g, {3'h0, seen});
            chk("group vec", {1'b1, `EPI_VEC_GRP0 + 5'(g)}, vec);
            wclr(g + 1);
            chk("write clear", 6'h00, {2'h0, flags});
        end
    endtask : t_groups
    task automatic t_ext;
        logic [1:0] md[3] = '{`EPI_SENSE_FALL, `EPI_SENSE_RISE, `EPI_SENSE_ANY};
        for (int i = 0; i < 3; i++) begin
            sense = md[i];
            pin = ~pin;
            cyc(6);
            chk("edge flag", 6'h01, {2'h0, flags});
            chk("ext vec", {1'b1, `EPI_VEC_EXT}, vec);
            wclr(0);
        end
        io_run = 1'b0;
        pin = 1'b1;
        cyc(6);
        chk("no clock edge", 6'h00, {2'h0, flags});
        io_run = 1'b1;
        // Flag is left set so that the level scenario can show it forced clear.
        sense = `EPI_SENSE_FALL;
        pin = 1'b0;
        cyc(2);
        pin = 1'b1;
        cyc(6);
        chk("short pulse", 6'h01, {2'h0, flags});
    endtask : t_ext
    task automatic t_level;
        sense = `EPI_SENSE_LOW;
        pin = 1'b0;
        cyc(6);
        chk("level flag", 6'h00, {2'h0, flags});
        chk("level vec", {1'b1, `EPI_VEC_EXT}, vec);
        cyc(20);
        chk("level held", {1'b1, `EPI_VEC_EXT}, vec);
        io_run = 1'b0;
        cyc(1);
        chk("level wake", 6'h01, {5'h0, wake});
        started = 1'b0;
        cyc(4);
        chk("early release", 6'h00, {5'h0, vec.valid});
        pin = 1'b1;
        io_run = 1'b1;
        started = 1'b1;
        cyc(4);
    endtask : t_level
    task automatic t_prio;
        int base;
        for (int s = 0; s < 2; s++) begin
            base = q.size();
            m_slow = s[0];
            other[12] = 1'b1;
            pc[7] = ~pc[7];
            pc[17] = ~pc[17];
            cyc(8);
            m_en = 1'b1;
            cyc(60);
            chk("first", {1'b0, `EPI_VEC_GRP0}, {1'b0, q[base]});
            chk("second", {1'b0, `EPI_VEC_GRP0 + 5'h2}, {1'b0, q[base+1]});
            chk("third", {1'b0, `EPI_VEC_OTHER_LAST}, {1'b0, q[base+2]});
            chk("serviced", 6'h00, {2'h0, flags});
            other = 13'h0;
            m_en = 1'b0;
            cyc(4);
        end
    endtask : t_prio
    task automatic give_verdict;
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : give_verdict
    initial begin
        #50000;
        err_count++;
        give_verdict();
    end
    initial begin
        repeat (8) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 1'b0;
        chk("reset vec", {1'b0, `EPI_VEC_RESET}, vec);
        chk("reset flags", 6'h00, {greq, 3'h0} | {2'h0, flags});
        cyc(4);
        t_groups();
        t_ext();
        t_level();
        t_prio();
        give_verdict();
    end
endmodule : epi_ctrl_test
